// ==== testbench/host_model.sv ====
// Purpose: far side: comparator decisions and the bus as the host sees it
// Assumes: decisions taken every 7 cycles, msb first
// Notes: released bus shows the inverse of the last word, so an idle read cannot pass
module host_model (
  input wire logic mclk,
  input wire logic busy,
  input wire logic [15:0] output_bus,
  input wire logic output_bus_oe_n,
  output logic comp_in,
  output logic [15:0] bus_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] busy_cyc = 8'h00;
  // ones for seven decisions, zeros after: result FE00
  assign comp_in = busy_cyc < 8'h34;
  assign bus_seen = output_bus_oe_n ? ~output_bus : output_bus;
  always @(posedge mclk) busy_cyc <= busy ? busy_cyc + 8'h01 : 8'h00;
endmodule // host_model

// ==== testbench/sar_adc_reset_readout_bench.sv ====
// Purpose: self-checking bench for the converter control
// Assumes: decisions come from host_model
// Notes: each scenario task judges its own reads
module sar_adc_reset_readout_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, rst = 1'b1, reset_n = 1'b1, chip_sel_n = 1'b0, read_n = 1'b1;
  logic byte_sel = 1'b0, convert_start_n = 1'b1, comp_in, busy, sampling, output_bus_oe_n;
  logic [15:0] output_bus, bus_seen;
  int err_total = 0, checks = 0;
  initial forever #2.5 mclk = ~mclk;
  sar_adc_reset_readout u_sar_adc_reset_readout (
    .mclk(mclk),
    .rst(rst),
    .reset_n(reset_n),
    .chip_sel_n(chip_sel_n),
    .read_n(read_n),
    .byte_sel(byte_sel),
    .convert_start_n(convert_start_n),
    .comp_in(comp_in),
    .busy(busy),
    .sampling(sampling),
    .output_bus(output_bus),
    .output_bus_oe_n(output_bus_oe_n)
  );
  host_model u_host_model (
    .mclk(mclk),
    .busy(busy),
    .output_bus(output_bus),
    .output_bus_oe_n(output_bus_oe_n),
    .comp_in(comp_in),
    .bus_seen(bus_seen)
  );
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(string what, logic exp, logic got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait; an overrun ends the run
  task automatic wait_busy(logic lvl);
    int n;
    @(negedge mclk);
    for (n = 0; n < 300 && busy !== lvl; n++) @(negedge mclk);
    if (n == 300) begin
      cmp_bit("busy wait", lvl, busy);
      tally_and_finish();
    end
  endtask
  task automatic convert();
    @(posedge mclk);
    chip_sel_n <= 1'b0;
    convert_start_n <= 1'b0;
    repeat (6) @(posedge mclk);
    convert_start_n <= 1'b1;
    wait_busy(1'b1);
  endtask
  task automatic read(logic bsel, logic [15:0] exp);
    @(posedge mclk);
    byte_sel <= bsel;
    read_n <= 1'b0;
    repeat (5) @(negedge mclk);
    cmp("bus", exp, bus_seen);
    @(posedge mclk);
    read_n <= 1'b1;
  endtask
  // warm-up conversions, then both lanes without a new conversion
  task automatic t_readout();
    repeat (3) begin
      convert();
      wait_busy(1'b0);
    end
    read(1'b0, 16'hFE00);
    read(1'b1, 16'h00FF);
  endtask
  // select high at busy fall holds sampling off until select falls
  task automatic t_sample_order();
    convert();
    repeat (20) @(posedge mclk);
    chip_sel_n <= 1'b1;
    wait_busy(1'b0);
    repeat (4) @(negedge mclk);
    cmp_bit("sampling", 1'b0, sampling);
    @(posedge mclk);
    chip_sel_n <= 1'b0;
    repeat (5) @(negedge mclk);
    cmp_bit("sampling", 1'b1, sampling);
  endtask
  task automatic t_tristate();
    @(posedge mclk);
    chip_sel_n <= 1'b1;
    read_n <= 1'b0;
    repeat (5) @(negedge mclk);
    cmp_bit("oe_n", 1'b1, output_bus_oe_n);
    @(posedge mclk);
    read_n <= 1'b1;
    chip_sel_n <= 1'b0;
  endtask
  // both aborts clear the result; the next conversion needs no release
  task automatic t_abort();
    convert();
    repeat (20) @(posedge mclk);
    chip_sel_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chip_sel_n <= 1'b0;
    repeat (12) @(negedge mclk);
    cmp_bit("busy", 1'b0, busy);
    read(1'b0, 16'h0000);
    convert();
    repeat (20) @(posedge mclk);
    convert_start_n <= 1'b0;
    repeat (6) @(posedge mclk);
    convert_start_n <= 1'b1;
    repeat (6) @(negedge mclk);
    cmp_bit("busy", 1'b0, busy);
    read(1'b0, 16'h0000);
    convert();
    wait_busy(1'b0);
    read(1'b0, 16'hFE00);
  endtask
  task automatic t_reset_pin();
    convert();
    repeat (30) @(posedge mclk);
    reset_n <= 1'b0;
    repeat (6) @(negedge mclk);
    cmp_bit("busy", 1'b0, busy);
    @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(negedge mclk);
    cmp_bit("sampling", 1'b0, sampling);
    @(negedge mclk);
    cmp_bit("sampling", 1'b1, sampling);
    read(1'b0, 16'h0000);
    convert();
    wait_busy(1'b0);
    read(1'b1, 16'h00FF);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    t_readout();
    t_sample_order();
    t_tristate();
    t_abort();
    t_reset_pin();
    tally_and_finish();
  end
endmodule // sar_adc_reset_readout_bench

// ==== testbench/sar_adc_reset_readout_chk.sv ====
// Purpose: port checks for the converter control
// Assumes: host pins reach the outputs three cycles late
// Notes: bound to every instance of the block
module sar_readout_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic byte_sel,
  input wire logic convert_start_n,
  input wire logic busy,
  input wire logic sampling,
  input wire logic [15:0] output_bus,
  input wire logic output_bus_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || !reset_n);
  // driving, quiet and timing relations at the pins
  chk_bus_enable: assert property (!output_bus_oe_n |-> $past(!chip_sel_n, 3) && $past(!read_n, 3))
    else $error("bus driven without select and read");
  chk_reset_quiet: assert property (disable iff (rst) !reset_n |-> !busy && !sampling && output_bus_oe_n)
    else $error("outputs active in reset");
  chk_first_sample: assert property ($rose(reset_n) |-> ##[1:6] sampling)
    else $error("no sampling after reset release");
  chk_abort_sel: assert property (busy && $fell(chip_sel_n) |-> ##[1:10] !busy)
    else $error("select fall did not abort");
  chk_abort_conv: assert property (busy && !chip_sel_n && $fell(convert_start_n) |-> ##[1:10] !busy)
    else $error("convert start did not abort");
  chk_busy_cause: assert property ($rose(busy) |-> $past(!chip_sel_n, 2) && !$past(convert_start_n, 2))
    else $error("busy without convert start");
  chk_busy_hold: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped early");
  chk_byte_fill: assert property (!output_bus_oe_n && $past(byte_sel, 3) && $past(byte_sel, 4)
    |-> output_bus[7:0] == 8'hFF)
    else $error("low lane not all ones");
  chk_sample_idle: assert property (sampling |-> !busy)
    else $error("sampling during conversion");
  cover property ($fell(busy));
  cover property (!output_bus_oe_n && byte_sel);
  cover property ($rose(reset_n));
endmodule // sar_readout_chk
bind sar_adc_reset_readout sar_readout_chk u_sar_readout_chk (
  .mclk(mclk),
  .rst(rst),
  .reset_n(reset_n),
  .chip_sel_n(chip_sel_n),
  .read_n(read_n),
  .byte_sel(byte_sel),
  .convert_start_n(convert_start_n),
  .busy(busy),
  .sampling(sampling),
  .output_bus(output_bus),
  .output_bus_oe_n(output_bus_oe_n)
);

// ==== verilog/sar_adc_reset_readout.sv ====
// Purpose: control of a 16-bit SAR converter: conversion, abort, reset, byte readout
// Assumes: host pins are asynchronous to mclk and pass two flops
// Notes: analog core is outside; comparator decision arrives on comp_in each bit
// Functional notes
// - byte select swaps bytes, low byte ones
// - reset pin asynchronous active low, ignores select
// - abort conversion within 50 ns of reset
// - reset clears output latches to zero
// - normal operation within 20 ns after release
// - first sampling 20 ns after release
// - later sampling at later busy/select fall
// - convert start during conversion resets device
// - select fall during conversion resets device
// - internal reset clears itself
// - power-on reset initialises device
// - busy high throughout conversion
// - bus driven only when select and read low
// - result in two's complement
// - convert start fall begins conversion
`include "sar_ctrl_defines.svh"
module sar_adc_reset_readout (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic byte_sel,
  input wire logic convert_start_n,
  input wire logic comp_in,
  output logic busy,
  output logic sampling,
  output logic [15:0] output_bus,
  output logic output_bus_oe_n
);
  import sar_ctrl_pkg::*;

  // release passes the reset synchroniser first, so the wake count is shortened by its depth
  localparam logic [7:0] FIRST_CYC = 8'(`FIRST_SAMPLE_CYC - `RST_SYNC_CYC);
  // the self reset pays the same release delay, so both paths reach sampling alike
  localparam logic [7:0] SELF_CYC = 8'(`SELF_RESET_CYC + `RST_SYNC_CYC);
  localparam logic [7:0] BIT_CYC = 8'(`BIT_CYC);

  // terminal count of the shared timer; wake, bit and self reset all use it
  function automatic logic count_done(input logic [7:0] count, input logic [7:0] limit);
    count_done = (count == limit - 8'h01);
  endfunction

  // raw reset request: power-on stand-in or the reset pin, no select gating
  logic reset_raw;
  assign reset_raw = rst | ~reset_n;

  // reset asserts at once but releases through two flops, so the pin's
  // rising edge never races the clock edge of the logic it frees
  logic [1:0] rst_sync;
  logic reset_pin_act;
  always_ff @(posedge mclk or posedge reset_raw) begin
    if (reset_raw) begin
      rst_sync <= 2'b11;
    end else begin
      rst_sync <= {rst_sync[0], 1'b0};
    end
  end
  assign reset_pin_act = rst_sync[1];

  // two-flop synchronisers for host pins
  logic [1:0] cs_sync, cv_sync, rd_sync, bs_sync;
  logic cs_prev, cv_prev;
  always_ff @(posedge mclk or posedge reset_pin_act) begin
    if (reset_pin_act) begin
      cs_sync <= 2'b11;
      cv_sync <= 2'b11;
      rd_sync <= 2'b11;
      bs_sync <= 2'b00;
      cs_prev <= 1'b1;
      cv_prev <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], chip_sel_n};
      cv_sync <= {cv_sync[0], convert_start_n};
      rd_sync <= {rd_sync[0], read_n};
      bs_sync <= {bs_sync[0], byte_sel};
      cs_prev <= cs_sync[1];
      cv_prev <= cv_sync[1];
    end
  end

  // edge decode on synchronised levels
  wire cs_low = ~cs_sync[1];
  wire cs_fall = cs_prev & ~cs_sync[1];
  wire cv_fall = cv_prev & ~cv_sync[1];
  wire start_conv = cv_fall & cs_low;

  conv_state_t state;
  logic [7:0] timer;
  logic [3:0] bit_idx;
  logic [15:0] sar_reg;
  logic [15:0] result;
  logic busy_seen;

  // abort triggers while converting: busy drops two cycles after the pin edge is first sampled, well under 50 ns
  wire abort_req = (state == ST_CONVERT) & (cv_fall & cs_low | cs_fall);
  wire bit_done = (state == ST_CONVERT) & count_done(timer, BIT_CYC);
  wire last_bit = bit_done & (bit_idx == 4'h0);
  // sampling after a conversion waits for the later of busy fall and select fall
  wire resume_sample = busy_seen & cs_low;

  // conversion sequencer; state and timer kept in one process
  always_ff @(posedge mclk or posedge reset_pin_act) begin
    if (reset_pin_act) begin
      state <= ST_WAKE;
      timer <= 8'h00;
    end else begin
      case (state)
        ST_WAKE: begin
          // first sampling starts a fixed time after release
          timer <= timer + 8'h01;
          if (count_done(timer, FIRST_CYC)) begin
            state <= ST_SAMPLE;
            timer <= 8'h00;
          end
        end
        ST_SAMPLE: begin
          timer <= 8'h00;
          if (start_conv) begin
            state <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (abort_req) begin
            state <= ST_SELF_RST;
            timer <= 8'h00;
          end else if (last_bit) begin
            state <= ST_SAMPLE;
            timer <= 8'h00;
          end else if (bit_done) begin
            timer <= 8'h00;
          end else begin
            timer <= timer + 8'h01;
          end
        end
        ST_SELF_RST: begin
          // self-clearing: hold a pin-width reset then behave as a release
          timer <= timer + 8'h01;
          if (count_done(timer, SELF_CYC)) begin
            state <= ST_WAKE;
            timer <= 8'h00;
          end
        end
        default: begin
          state <= ST_WAKE;
          timer <= 8'h00;
        end
      endcase
    end
  end

  // successive approximation; msb first, sign bit kept in two's complement
  always_ff @(posedge mclk or posedge reset_pin_act) begin
    if (reset_pin_act) begin
      bit_idx <= 4'hF;
      sar_reg <= `RESULT_RST;
    end else if (state != ST_CONVERT) begin
      bit_idx <= 4'hF;
      sar_reg <= `RESULT_RST;
    end else if (bit_done) begin
      sar_reg[bit_idx] <= comp_in;
      bit_idx <= bit_idx - 4'h1;
    end
  end

  // output latch; the self reset clears it like the pin does
  always_ff @(posedge mclk or posedge reset_pin_act) begin
    if (reset_pin_act) begin
      result <= `RESULT_RST;
    end else if (state == ST_SELF_RST) begin
      result <= `RESULT_RST;
    end else if (last_bit & ~abort_req) begin
      result <= {sar_reg[15:1], comp_in};
    end
  end

  // remembers that busy has fallen until select is also low
  // a new conversion end outranks a clear in the same cycle
  always_ff @(posedge mclk or posedge reset_pin_act) begin
    if (reset_pin_act) begin
      busy_seen <= 1'b0;
    end else if (last_bit & ~abort_req) begin
      busy_seen <= 1'b1;
    end else if (resume_sample | start_conv) begin
      busy_seen <= 1'b0;
    end
  end

  // status outputs
  // sampling is a level: high through the sampling period until convert start
  always_ff @(posedge mclk or posedge reset_pin_act) begin
    if (reset_pin_act) begin
      busy <= 1'b0;
      sampling <= 1'b0;
    end else begin
      busy <= (state == ST_CONVERT) & ~last_bit & ~abort_req | (state == ST_SAMPLE) & start_conv;
      sampling <= (state == ST_SAMPLE) & ~start_conv & (~busy_seen | resume_sample) |
                  (state == ST_WAKE) & count_done(timer, FIRST_CYC);
    end
  end

  // byte steering is combinational on the synchronised byte select
  wire [15:0] bus_word = bs_sync[1] ? {result[7:0], `LOW_BYTE_FILL} : result;
  wire bus_en = cs_low & ~rd_sync[1];

  // data registered; enable low while driving
  always_ff @(posedge mclk or posedge reset_pin_act) begin
    if (reset_pin_act) begin
      output_bus <= 16'h0000;
      output_bus_oe_n <= 1'b1;
    end else begin
      output_bus <= bus_word;
      output_bus_oe_n <= ~bus_en;
    end
  end
endmodule // sar_adc_reset_readout

// ==== verilog/sar_ctrl_defines.svh ====
// Purpose: constants for the converter control block
// Assumes: mclk at 200 MHz
// Notes: times in ns, counts derived from them
`ifndef SAR_CTRL_DEFINES_SVH
`define SAR_CTRL_DEFINES_SVH
`define CLK_PERIOD_NS 5
`define RESET_LOW_MIN_NS 25
`define ABORT_MAX_NS 50
`define RESUME_MAX_NS 20
`define FIRST_SAMPLE_NS 20
`define FIRST_SAMPLE_CYC ((`FIRST_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_SYNC_CYC 2
`define SELF_RESET_NS 25
`define SELF_RESET_CYC ((`SELF_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS 610
`define CONV_CYC (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define BIT_CYC 7
`define RESULT_W 16
`define RESULT_RST 16'h0000
`define LOW_BYTE_FILL 8'hFF
`endif

// ==== verilog/sar_ctrl_pkg.sv ====
// Purpose: types for the converter control block
// Assumes: nothing
// Notes: state codes written out
package sar_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_WAKE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10,
    ST_SELF_RST = 2'b11
  } conv_state_t;
endpackage
